// ### core/soft_start_defs.vh
// constants for the soft start ramp control
`ifndef SOFT_START_DEFS_VH
`define SOFT_START_DEFS_VH
`define CLK_HZ            100000000
`define TICK_MS           1
`define TICK_CYCLES       ((`CLK_HZ / 1000) * `TICK_MS)
`define MS_PER_SEC        1000
`define TIMEOUT_MIN_S     9'h001
`define TIMEOUT_MAX_S     9'h12C
`define TIMEOUT_RST_S     9'h014
`define RAMP_MAX_S        9'h12C
`define RAMP_RST_S        9'h00F
`define START_MIN_PCT     10'h032
`define START_MAX_PCT     10'h258
`define START_RST_PCT     10'h064
`define CEIL_MIN_PCT      10'h064
`define CEIL_MAX_PCT      10'h320
`define CEIL_RST_PCT      10'h258
`define SETTLE_PCT        10'h0AF
`define FULL_REF_PCT      10'h064
`define METHOD_VOLTAGE    3'h0
`define METHOD_CURRENT    3'h1
`define METHOD_TORQUE     3'h2
`define METHOD_POWER      3'h3
`define METHOD_TACH       3'h4
`define FAULT_UP_TO_SPEED 8'h01
`define FAULT_NONE        8'h00
`endif

// ### core/sec_timebase.v
// millisecond tick and elapsed-milliseconds counter for one start attempt
`timescale 1ns/100ps
`include "soft_start_defs.vh"
module sec_timebase #(
   parameter TICK_CYCLES = `TICK_CYCLES
) (
   input  wire        clk,
   input  wire        resetn,
   input  wire        run,
   output reg         ms_tick_q,
   output reg  [18:0] elapsed_ms_q
);
   reg [31:0] div_q;

   always @(posedge clk) begin
      if (!resetn || !run) begin
         div_q        <= 32'h0;
         ms_tick_q    <= 1'b0;
         elapsed_ms_q <= 19'h0;
      end else if (div_q == TICK_CYCLES - 1) begin
         div_q     <= 32'h0;
         ms_tick_q <= 1'b1;
         if (elapsed_ms_q != 19'h7FFFF) begin
            elapsed_ms_q <= elapsed_ms_q + 19'h1;
         end
      end else begin
         div_q     <= div_q + 32'h1;
         ms_tick_q <= 1'b0;
      end
   end
endmodule

// ### core/soft_start_ramp.v
// acceleration ramp and up-to-speed supervision of a soft starter
//
// Contract
// (RULE_01) speed timeout 1..300 s, default 20
// (RULE_02) up to speed: current below 175%, ramp done
// (RULE_03) timeout before up to speed: fault 01
// (RULE_04) timeout never raised to cover ramp
// (RULE_05) user sets timeout above ramp plus kick
// (RULE_06) voltage ramp: full voltage at timeout
// (RULE_07) wye-delta: transition at timeout if pending
// (RULE_08) five methods, current ramp by default
// (RULE_09) reference ramps start to ceiling over duration
// (RULE_10) hold ceiling until speed, timeout, overload
// (RULE_11) start current 50..600%, default 100
// (RULE_12) user keeps start current below ceiling
// (RULE_13) ceiling 100..800%, default 600, ramp end
// (RULE_14) set b uses its own ramp duration
// (RULE_15) set b uses its own start current
// (RULE_16) set b uses its own ceiling current
// (RULE_17) user configures tach settings before use
// (RULE_18) ramp set input sampled at start command
`timescale 1ns/100ps
`include "soft_start_defs.vh"
module soft_start_ramp #(
   parameter TICK_CYCLES = `TICK_CYCLES
) (
   input  wire        clk,
   input  wire        resetn,
   input  wire        start_cmd,
   input  wire        stop_cmd,
   input  wire        overload_trip,
   input  wire [9:0]  motor_current_pct,
   input  wire        ramp_set_input_en,
   input  wire        ramp_set_pin,
   input  wire        wye_delta_topology,
   input  wire        wye_delta_done,
   input  wire        cfg_write,
   input  wire [2:0]  accel_method_select,
   input  wire [8:0]  speed_timeout_setting,
   input  wire [8:0]  ramp_duration_a,
   input  wire [9:0]  start_current_a,
   input  wire [9:0]  ceiling_current_a,
   input  wire [8:0]  ramp_duration_b,
   input  wire [9:0]  start_current_b,
   input  wire [9:0]  ceiling_current_b,
   output reg  [9:0]  control_ref_q,
   output reg         full_voltage_q,
   output reg         delta_transition_q,
   output reg         up_to_speed_q,
   output reg         accelerating_q,
   output reg  [7:0]  fault_code_q,
   output reg         fault_q,
   output reg         set_b_active_q,
   output reg  [2:0]  method_q
);
   localparam ST_IDLE  = 2'b00;
   localparam ST_RAMP  = 2'b01;
   localparam ST_RUN   = 2'b10;
   localparam ST_FAULT = 2'b11;

   reg  [1:0]  state_q;
   reg  [8:0]  timeout_q;
   reg  [8:0]  dur_a_q;
   reg  [8:0]  dur_b_q;
   reg  [9:0]  start_a_q;
   reg  [9:0]  ceil_a_q;
   reg  [9:0]  start_b_q;
   reg  [9:0]  ceil_b_q;
   reg  [8:0]  dur_q;
   reg  [9:0]  start_q;
   reg  [9:0]  ceil_q;
   reg  [2:0]  pin_sync_q;
   reg         set_pin_q;
   wire        use_b;
   wire [18:0] elapsed_ms;
   wire [18:0] ramp_ms;
   wire [18:0] timeout_ms;
   wire        ramp_done;
   wire        timed_out;
   wire        settled;
   wire [9:0]  span;
   wire [28:0] prod;
   wire [9:0]  ramp_ref;
   wire [9:0]  ref_end;
   wire [9:0]  ref_begin;
   reg  [9:0]  ref_d;

   sec_timebase #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_timebase (
      .clk          (clk),
      .resetn       (resetn),
      .run          (state_q == ST_RAMP || state_q == ST_RUN),
      .ms_tick_q    (),
      .elapsed_ms_q (elapsed_ms)
   );

   // ramp select pin is asynchronous: three stages, change when 2 and 3 agree
   always @(posedge clk) begin
      if (!resetn) begin
         pin_sync_q <= 3'h0;
         set_pin_q  <= 1'b0;
      end else begin
         pin_sync_q <= {pin_sync_q[1:0], ramp_set_pin};
         if (pin_sync_q[1] == pin_sync_q[2]) begin
            set_pin_q <= pin_sync_q[2];
         end
      end
   end

   // settings store with range clamping
   always @(posedge clk) begin
      if (!resetn) begin
         method_q  <= `METHOD_CURRENT;                          // see RULE_08
         timeout_q <= `TIMEOUT_RST_S;                           // see RULE_01
         dur_a_q   <= `RAMP_RST_S;                              // see RULE_09
         start_a_q <= `START_RST_PCT;                           // see RULE_11
         ceil_a_q  <= `CEIL_RST_PCT;                            // see RULE_13
         dur_b_q   <= `RAMP_RST_S;                              // see RULE_14
         start_b_q <= `START_RST_PCT;                           // see RULE_15
         ceil_b_q  <= `CEIL_RST_PCT;                            // see RULE_16
      end else if (cfg_write && state_q == ST_IDLE) begin
         method_q  <= (accel_method_select > `METHOD_TACH) ? method_q : accel_method_select;
         timeout_q <= (speed_timeout_setting < `TIMEOUT_MIN_S) ? `TIMEOUT_MIN_S :
                      (speed_timeout_setting > `TIMEOUT_MAX_S) ? `TIMEOUT_MAX_S :
                      speed_timeout_setting;                    // see RULE_01
         dur_a_q   <= (ramp_duration_a > `RAMP_MAX_S) ? `RAMP_MAX_S : ramp_duration_a;
         dur_b_q   <= (ramp_duration_b > `RAMP_MAX_S) ? `RAMP_MAX_S : ramp_duration_b;
         start_a_q <= (start_current_a < `START_MIN_PCT) ? `START_MIN_PCT :
                      (start_current_a > `START_MAX_PCT) ? `START_MAX_PCT : start_current_a;
         start_b_q <= (start_current_b < `START_MIN_PCT) ? `START_MIN_PCT :
                      (start_current_b > `START_MAX_PCT) ? `START_MAX_PCT : start_current_b;
         ceil_a_q  <= (ceiling_current_a < `CEIL_MIN_PCT) ? `CEIL_MIN_PCT :
                      (ceiling_current_a > `CEIL_MAX_PCT) ? `CEIL_MAX_PCT : ceiling_current_a;
         ceil_b_q  <= (ceiling_current_b < `CEIL_MIN_PCT) ? `CEIL_MIN_PCT :
                      (ceiling_current_b > `CEIL_MAX_PCT) ? `CEIL_MAX_PCT : ceiling_current_b;
      end
   end

   assign ramp_ms    = dur_q * 19'd1000;
   assign timeout_ms = timeout_q * 19'd1000;
   assign ramp_done  = (elapsed_ms >= ramp_ms);
   // timeout is compared as set, never stretched to fit the ramp
   assign timed_out  = (elapsed_ms >= timeout_ms);               // see RULE_04
   assign settled    = (motor_current_pct < `SETTLE_PCT);
   assign use_b      = ramp_set_input_en & set_pin_q;

   // voltage ramp ends at full voltage; other methods end at the ceiling
   assign ref_end   = (method_q == `METHOD_VOLTAGE) ? `FULL_REF_PCT : ceil_q;
   assign ref_begin = (method_q == `METHOD_VOLTAGE) ? 10'h000 : start_q;
   assign span      = (ref_end > ref_begin) ? (ref_end - ref_begin) : 10'h000;
   assign prod      = (ramp_ms == 19'h0) ? 29'h0 :
                      ({19'h0, span} * {10'h0, elapsed_ms}) / {10'h0, ramp_ms};
   assign ramp_ref  = ramp_done ? ref_end : (ref_begin + prod[9:0]); // see RULE_09

   always @* begin
      ref_d = control_ref_q;
      case (state_q)
         ST_RAMP: ref_d = ramp_ref;
         ST_RUN:  ref_d = ref_end;
         default: ref_d = 10'h000;
      endcase
   end

   always @(posedge clk) begin
      if (!resetn) begin
         state_q            <= ST_IDLE;
         dur_q              <= `RAMP_RST_S;
         start_q            <= `START_RST_PCT;
         ceil_q             <= `CEIL_RST_PCT;
         set_b_active_q     <= 1'b0;
         control_ref_q      <= 10'h000;
         full_voltage_q     <= 1'b0;
         delta_transition_q <= 1'b0;
         up_to_speed_q      <= 1'b0;
         accelerating_q     <= 1'b0;
         fault_code_q       <= `FAULT_NONE;
         fault_q            <= 1'b0;
      end else begin
         control_ref_q <= ref_d;
         case (state_q)
            ST_IDLE: begin
               full_voltage_q     <= 1'b0;
               delta_transition_q <= 1'b0;
               up_to_speed_q      <= 1'b0;
               if (start_cmd && !stop_cmd) begin
                  // set chosen once per start; no input configured means set a
                  set_b_active_q <= use_b;                              // see RULE_18
                  dur_q   <= use_b ? dur_b_q : dur_a_q;                 // see RULE_14
                  start_q <= use_b ? start_b_q : start_a_q;             // see RULE_15
                  ceil_q  <= use_b ? ceil_b_q : ceil_a_q;               // see RULE_16
                  control_ref_q  <= (method_q == `METHOD_VOLTAGE) ? 10'h000 :
                                    (use_b ? start_b_q : start_a_q);    // see RULE_11
                  accelerating_q <= 1'b1;
                  fault_q        <= 1'b0;
                  fault_code_q   <= `FAULT_NONE;
                  state_q        <= ST_RAMP;
               end
            end
            ST_RAMP: begin
               if (stop_cmd || overload_trip) begin
                  accelerating_q <= 1'b0;                       // see RULE_10
                  state_q        <= ST_IDLE;
               end else if (ramp_done && settled && !timed_out) begin
                  up_to_speed_q  <= 1'b1;                       // see RULE_02
                  accelerating_q <= 1'b0;
                  state_q        <= ST_RUN;
               end else if (timed_out) begin
                  if (method_q == `METHOD_VOLTAGE) begin
                     full_voltage_q <= 1'b1;                    // see RULE_06
                  end
                  if (wye_delta_topology && !wye_delta_done) begin
                     delta_transition_q <= 1'b1;                // see RULE_07
                  end
                  fault_q        <= 1'b1;                       // see RULE_03
                  fault_code_q   <= `FAULT_UP_TO_SPEED;
                  accelerating_q <= 1'b0;
                  state_q        <= ST_FAULT;
               end
            end
            ST_RUN: begin
               if (stop_cmd || overload_trip) begin
                  up_to_speed_q <= 1'b0;
                  state_q       <= ST_IDLE;
               end
            end
            default: begin
               // fault holds until the start command is withdrawn
               if (!start_cmd) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end
endmodule

// ### test/soft_start_ramp_properties.sv
// port-level checks of the soft start ramp control
`timescale 1ns/100ps
module soft_start_props (
   input wire       clk,
   input wire       resetn,
   input wire       start_cmd,
   input wire       stop_cmd,
   input wire       overload_trip,
   input wire [9:0] motor_current_pct,
   input wire       wye_delta_topology,
   input wire [9:0] control_ref_q,
   input wire       full_voltage_q,
   input wire       delta_transition_q,
   input wire       up_to_speed_q,
   input wire       accelerating_q,
   input wire [7:0] fault_code_q,
   input wire       fault_q,
   input wire [2:0] method_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_code; fault_q |-> fault_code_q == 8'h01; endproperty
   a_code: assert property (p_code) else $error("bad fault code");
   property p_uts;
      $rose(up_to_speed_q) |->
         ($past(motor_current_pct) < 10'h0AF || $past(motor_current_pct, 2) < 10'h0AF);
   endproperty
   a_uts: assert property (p_uts) else $error("speed flag at high current");
   property p_excl; up_to_speed_q |-> !fault_q; endproperty
   a_excl: assert property (p_excl) else $error("speed flag with fault");
   property p_fullv; $rose(full_voltage_q) |-> fault_q && method_q == 3'h0; endproperty
   a_fullv: assert property (p_fullv) else $error("full voltage out of place");
   property p_delta; $rose(delta_transition_q) |-> fault_q && wye_delta_topology; endproperty
   a_delta: assert property (p_delta) else $error("transition out of place");
   property p_start;
      start_cmd && !stop_cmd && !overload_trip && !accelerating_q && !up_to_speed_q
         && !fault_q |=> accelerating_q;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");
   property p_stop; (stop_cmd || overload_trip) && accelerating_q |=> !accelerating_q && !fault_q;
   endproperty
   a_stop: assert property (p_stop) else $error("abort not honoured");
   property p_mono;
      accelerating_q && $past(accelerating_q) |-> control_ref_q >= $past(control_ref_q);
   endproperty
   a_mono: assert property (p_mono) else $error("reference fell in ramp");
   c_uts: cover property ($rose(up_to_speed_q));
   c_fault: cover property ($rose(fault_q));
   c_fullv: cover property ($rose(full_voltage_q));
endmodule
bind soft_start_ramp soft_start_props i_props (.clk(clk), .resetn(resetn),
   .start_cmd(start_cmd), .stop_cmd(stop_cmd), .overload_trip(overload_trip),
   .motor_current_pct(motor_current_pct), .wye_delta_topology(wye_delta_topology),
   .control_ref_q(control_ref_q), .full_voltage_q(full_voltage_q),
   .delta_transition_q(delta_transition_q), .up_to_speed_q(up_to_speed_q),
   .accelerating_q(accelerating_q), .fault_code_q(fault_code_q), .fault_q(fault_q),
   .method_q(method_q));

// ### test/motor_model.sv
// behavioural power stage and motor returning measured current
`timescale 1ns/100ps
module motor_model (
   input  wire       clk,
   input  wire       stall,
   input  wire       accelerating,
   input  wire [9:0] drive_ref,
   output reg  [9:0] current_pct
);
   reg [7:0] spin_q;
   initial current_pct = 10'h000;
   initial spin_q = 8'h00;
   always @(posedge clk) begin
      spin_q <= !accelerating ? 8'h00 : (spin_q == 8'hFF ? spin_q : spin_q + 8'h01);
      // locked rotor keeps current high
      if (stall) current_pct <= 10'h1F4;
      else if (accelerating) current_pct <= (spin_q < 8'h32) ? drive_ref : 10'h064;
      else current_pct <= 10'h03C;
   end
endmodule

// ### test/testbench.sv
// random and corner-case bench for the soft start ramp control
`timescale 1ns/100ps
`define CHK(a,b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
module testbench;
   localparam TK = 1;
   reg        clk, resetn, start_cmd, stop_cmd, overload_trip, stall, cfg_write;
   reg        ramp_set_input_en, ramp_set_pin, wye_delta_topology, wye_delta_done;
   reg  [2:0] accel_method_select;
   reg  [8:0] speed_timeout_setting, ramp_duration_a, ramp_duration_b;
   reg  [9:0] start_current_a, ceiling_current_a, start_current_b, ceiling_current_b;
   wire [9:0] motor_current_pct, control_ref_q;
   wire [7:0] fault_code_q;
   wire [2:0] method_q;
   wire       full_voltage_q, delta_transition_q, up_to_speed_q, accelerating_q;
   wire       fault_q, set_b_active_q;
   reg [31:0] rs;
   integer    err_count, cmp_count, i, n;
   reg        ef, b;
   reg  [9:0] s0, c0, lo, hi;
   reg  [8:0] rd;
   soft_start_ramp #(.TICK_CYCLES(TK)) i_dut (.clk(clk), .resetn(resetn),
      .start_cmd(start_cmd), .stop_cmd(stop_cmd), .overload_trip(overload_trip),
      .motor_current_pct(motor_current_pct), .ramp_set_input_en(ramp_set_input_en),
      .ramp_set_pin(ramp_set_pin), .wye_delta_topology(wye_delta_topology),
      .wye_delta_done(wye_delta_done), .cfg_write(cfg_write),
      .accel_method_select(accel_method_select),
      .speed_timeout_setting(speed_timeout_setting), .ramp_duration_a(ramp_duration_a),
      .start_current_a(start_current_a), .ceiling_current_a(ceiling_current_a),
      .ramp_duration_b(ramp_duration_b), .start_current_b(start_current_b),
      .ceiling_current_b(ceiling_current_b), .control_ref_q(control_ref_q),
      .full_voltage_q(full_voltage_q), .delta_transition_q(delta_transition_q),
      .up_to_speed_q(up_to_speed_q), .accelerating_q(accelerating_q),
      .fault_code_q(fault_code_q), .fault_q(fault_q), .set_b_active_q(set_b_active_q),
      .method_q(method_q));
   motor_model i_motor (.clk(clk), .stall(stall), .accelerating(accelerating_q),
      .drive_ref(control_ref_q), .current_pct(motor_current_pct));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task stop_test;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, err_count);
         if (err_count == 0 && cmp_count > 0) $display("verification passed");
         else $display("verification failed");
         $finish;
      end
   endtask
   // linear ramp point after t ms of a len ms ramp
   function [9:0] exp_ref(input [9:0] lo_v, input [9:0] hi_v, input integer t,
                          input integer len);
      begin
         exp_ref = (t >= len) ? hi_v : lo_v + ((hi_v - lo_v) * t) / len;
      end
   endfunction
   task run_start(input st, input ovl);
      begin
         b = ramp_set_input_en & ramp_set_pin;
         s0 = b ? start_current_b : start_current_a;
         c0 = b ? ceiling_current_b : ceiling_current_a;
         rd = b ? ramp_duration_b : ramp_duration_a;
         ef = st | (rd > speed_timeout_setting);
         lo = (accel_method_select == 3'h0) ? 10'h000 : s0;
         hi = (accel_method_select == 3'h0) ? 10'h064 : c0;
         stall = st;
         repeat (4) @(posedge clk);
         #1 cfg_write = 1;
         @(posedge clk);
         #1 cfg_write = 0;
         start_cmd = 1;
         @(posedge clk);
         #1 `CHK(accelerating_q, 1'b1)
         `CHK(set_b_active_q, b)
         `CHK(method_q, accel_method_select)
         if (accel_method_select != 3'h0) `CHK(control_ref_q, s0)
         n = 1;
         while (accelerating_q === 1'b1 && n < 9000) begin
            if (ovl && n == 50) overload_trip = 1;
            if (n == rd * 1000 * TK + 8 && accel_method_select != 3'h0)
               `CHK(control_ref_q, c0)
            if (rd != 0 && n == rd * 500 * TK + 2)
               `CHK(control_ref_q, exp_ref(lo, hi, n - 2, rd * 1000 * TK))
            @(posedge clk);
            #1 n = n + 1;
         end
         if (ovl) `CHK({fault_q, up_to_speed_q}, 2'b00)
         else begin
            `CHK(fault_q, ef)
            `CHK({up_to_speed_q, fault_code_q}, {!ef, ef ? 8'h01 : 8'h00})
            if (ef) `CHK(n >= speed_timeout_setting * 1000 * TK - 2, 1'b1)
            if (ef) `CHK(n <= speed_timeout_setting * 1000 * TK + 4, 1'b1)
            if (!ef) `CHK(n >= rd * 1000 * TK, 1'b1)
            if (!ef && accel_method_select != 3'h0) `CHK(control_ref_q, c0)
            `CHK(full_voltage_q, ef && accel_method_select == 3'h0)
            `CHK(delta_transition_q, ef && wye_delta_topology && !wye_delta_done)
         end
         start_cmd = 0;
         stop_cmd = 1;
         overload_trip = 0;
         stall = 0;
         @(posedge clk);
         #1 stop_cmd = 0;
         $display("test done method %0d fault %0d cycles %0d", accel_method_select, ef, n);
      end
   endtask
   initial begin
      #500000 err_count = err_count + 1;
      stop_test;
   end
   initial begin
      {resetn, start_cmd, stop_cmd, overload_trip, stall, cfg_write} = 6'h00;
      {ramp_set_input_en, ramp_set_pin, wye_delta_topology, wye_delta_done} = 4'h0;
      {accel_method_select, speed_timeout_setting, ramp_duration_a} = {3'h1, 9'h014, 9'h00F};
      {start_current_a, ceiling_current_a} = {10'h064, 10'h258};
      {ramp_duration_b, start_current_b, ceiling_current_b} = {9'h00F, 10'h064, 10'h258};
      err_count = 0;
      cmp_count = 0;
      rs = 32'd17;
      repeat (2) @(posedge clk);
      #1 resetn = 1;
      `CHK({method_q, fault_code_q, accelerating_q}, 12'h200)
      for (i = 0; i < 12; i = i + 1) begin
         rs = rs ^ (rs << 13);
         rs = rs ^ (rs >> 17);
         rs = rs ^ (rs << 5);
         accel_method_select = i % 5;
         speed_timeout_setting = 9'h001 + rs[1:0] % 3;
         ramp_duration_a = rs[3:2] % speed_timeout_setting;
         ramp_duration_b = rs[5:4] % speed_timeout_setting;
         start_current_a = 10'h032 + rs[11:6];
         ceiling_current_a = 10'h0C8 + rs[17:12];
         start_current_b = 10'h032 + rs[23:18];
         ceiling_current_b = 10'h0C8 + rs[29:24];
         {ramp_set_input_en, ramp_set_pin, wye_delta_topology, wye_delta_done} = rs[31:28];
         if (i == 6) {wye_delta_topology, wye_delta_done} = 2'b10;
         if (i >= 10) ramp_set_input_en = 1'b0;
         // ramp longer than timeout must fault
         if (i == 10) {speed_timeout_setting, ramp_duration_a} = {9'h001, 9'h002};
         // ramp still running when the overload strikes
         if (i == 11) {speed_timeout_setting, ramp_duration_a} = {9'h003, 9'h002};
         run_start(i == 5 || i == 6, i == 11);
      end
      // undefined method code leaves the active method alone
      accel_method_select = 3'h7;
      @(posedge clk);
      #1 cfg_write = 1;
      @(posedge clk);
      #1 cfg_write = 0;
      `CHK(method_q, 3'h1)
      stop_test;
   end
endmodule
